// [hw/snh_ctrl.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - device keeps 20 remap links, numbered zero to nineteen.
// RULE2 - remap read: A5h, 8 dummy clocks, then 16-bit logical, 16-bit replacement index.
// RULE3 - links come out from link zero; unused links read as zeros.
// RULE4 - top two logical bits: 00 free, 10 valid, 11 invalid, 01 unused.
// RULE5 - with correction on, program execute writes parity into the spare area.
// RULE6 - reads with correction on check parity and update result bits.
// RULE7 - after failing continuous read, A9h plus dummy returns last failing page.
// RULE8 - erase: D8h, 8 dummy clocks, 16-bit page address; block becomes FFh.
// RULE9 - erase refused unless write latch flag set; host sends write enable first.
// RULE10 - chip select rises right after last erase bit is latched.
// RULE11 - after valid erase busy stays 1, then busy and latch flag clear.
// RULE12 - erase and program skipped inside the protected range.
// RULE13 - load: latch flag set, 02h or 84h, 16-bit column, at least one byte.
// RULE14 - chip select stays low for whole load; excess bytes are dropped.
// RULE15 - normal load pads unwritten bytes with FFh; random load leaves them.
// RULE16 - correction on overwrites spare parity positions; off keeps spare bytes.
// RULE17 - 32h and 34h are quad forms of normal and random load.
// RULE18 - write-protect pin mode bit at 1 disables all quad instructions.
// RULE19 - program execute: 10h, dummy, page; busy until done, latch flag clears.
// RULE20 - host makes at most four partial programs on one page.
// RULE21 - host programs pages of a block in ascending order.
// RULE22 - write enable 06h sets the write latch flag.
// RULE23 - status read 0Fh is accepted at any time, even while busy.
// RULE24 - with all 20 links written, the full flag sets; no more links.
// RULE25 - while busy only status reads are honoured.
module snh_ctrl import snh_pkg::*; (
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	output logic             SPI_SCK,
	output logic             SPI_CS_N,
	output logic      [3:0]  IO_OUT,
	output logic      [3:0]  IO_OE,
	input  wire logic [3:0]  IO_IN
);
	snh_state_t  st_reg;
	snh_stage_t  stage_reg;
	snh_phase_t  ph_reg;
	logic [7:0]  op_reg;
	logic [7:0]  eo;
	logic [15:0] addr_reg;
	logic [6:0]  len_reg;
	logic        wpm_reg;
	logic        refused_reg;
	logic [7:0]  stat_byte_reg;
	logic [15:0] eccpg_reg;
	logic [31:0] hdr_reg;
	logic [31:0] rxsh_reg;
	logic [5:0]  left_reg;
	logic [9:0]  rxn_reg;
	logic [9:0]  rxtot_reg;
	logic [6:0]  dcnt_reg;
	logic [6:0]  dptr_reg;
	logic [2:0]  dbit_reg;
	logic [7:0]  dsh_reg;
	logic        quad_reg;
	logic [7:0]  div_reg;
	logic [1:0]  gap_reg;
	logic [3:0]  io_m_reg;
	logic [3:0]  io_s_reg;

	logic [7:0]  buf_mem [BUF_BYTES];
	logic [31:0] remap_mem [REMAP_LINKS];
	logic [15:0] last_pg_reg;
	logic [2:0]  pg_cnt_reg;
	logic        have_pg_reg;

	logic        tick;
	logic        cmd_wr;
	logic        cmd_ok;
	logic        prog_bad;
	logic        accept;
	logic [7:0]  nb;

	// pins come from the far clock domain
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			io_m_reg <= 4'h0;
			io_s_reg <= 4'h0;
		end else begin
			io_m_reg <= IO_IN;
			io_s_reg <= io_m_reg;
		end
	end

	// restarted in setup so the first half period is never short
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			div_reg <= 8'h00;
		else if (st_reg == ST_SETUP || tick)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end
	assign tick = div_reg == 8'(SCK_HALF_CYC - 1);

	always_comb begin
		case (stage_reg)
			SG_WEN:  eo = OP_WEN; // [RULE22]
			SG_POLL: eo = OP_STAT; // [RULE23]
			default: eo = op_reg;
		endcase
	end

	// ascending order and partial count checked within the last block used
	assign prog_bad = have_pg_reg && addr_reg[15:6] == last_pg_reg[15:6]
		&& (addr_reg < last_pg_reg
		|| (addr_reg == last_pg_reg && pg_cnt_reg == PARTIAL_MAX)); // [RULE20] [RULE21]
	// a refused write never reaches the link; software sees the refused bit only for writes made while idle
	assign cmd_wr = WR && ADDR == REG_CMD;
	assign cmd_ok = st_reg == ST_IDLE && valid_op(WDATA[7:0])
		&& !(is_quad(WDATA[7:0]) && wpm_reg) // [RULE18]
		&& !(is_load(WDATA[7:0]) && len_reg == 7'h00) // [RULE13]
		&& !(WDATA[7:0] == OP_PEXEC && prog_bad);
	assign accept = cmd_wr && cmd_ok;

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			have_pg_reg <= 1'b0;
			last_pg_reg <= 16'h0000;
			pg_cnt_reg  <= 3'h0;
		end else if (accept && WDATA[7:0] == OP_ERASE) begin
			if (addr_reg[15:6] == last_pg_reg[15:6])
				have_pg_reg <= 1'b0;
		end else if (accept && WDATA[7:0] == OP_PEXEC) begin
			have_pg_reg <= 1'b1;
			last_pg_reg <= addr_reg;
			pg_cnt_reg  <= (have_pg_reg && addr_reg == last_pg_reg)
				? pg_cnt_reg + 3'h1 : 3'h1; // [RULE20]
		end
	end

	// software side; buffer is frozen while a transfer runs
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			addr_reg <= ADDR_RST;
			len_reg  <= LEN_RST;
			wpm_reg  <= 1'b0;
		end else if (WR) begin
			if (ADDR == REG_ADDR)
				addr_reg <= WDATA[15:0];
			if (ADDR == REG_LEN)
				len_reg <= (WDATA[7:0] > 8'(BUF_BYTES)) ? 7'(BUF_BYTES) : WDATA[6:0];
			if (ADDR == REG_CFG)
				wpm_reg <= WDATA[0];
		end
	end

	// no reset: the buffer is only sent after software fills it
	always_ff @(posedge SYS_CLK) begin
		if (WR && ADDR[7:6] == REG_BUF_HI && st_reg == ST_IDLE) begin
			for (int i = 0; i < 4; i++)
				buf_mem[{ADDR[5:2], 2'(i)}] <= WDATA[8*i +: 8];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			// unmapped addresses read as zero
			RDATA <= 32'h00000000;
			if (ADDR == REG_ADDR)
				RDATA <= {16'h0000, addr_reg};
			else if (ADDR == REG_LEN)
				RDATA <= {25'h0000000, len_reg};
			else if (ADDR == REG_CFG)
				RDATA <= {31'h00000000, wpm_reg};
			else if (ADDR == REG_STAT)
				RDATA <= {16'h0000, stat_byte_reg, 6'h00, refused_reg, st_reg != ST_IDLE};
			else if (ADDR == REG_ECCPG)
				RDATA <= {16'h0000, eccpg_reg};
			else if (ADDR[7:6] == REG_BUF_HI)
				for (int i = 0; i < 4; i++)
					RDATA[8*i +: 8] <= buf_mem[{ADDR[5:2], 2'(i)}];
			else if (ADDR >= REG_REMAP && ADDR[6:2] < 5'(REMAP_LINKS))
				RDATA <= remap_mem[ADDR[6:2]];
		end
	end

	assign nb = buf_mem[dptr_reg[5:0]];

	// one engine runs every frame: enable for loads and timed commands, main frame, then status polls for timed ones

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_reg        <= ST_IDLE;
			stage_reg     <= SG_WEN;
			ph_reg        <= PH_HDR;
			op_reg        <= 8'h00;
			refused_reg   <= 1'b0;
			stat_byte_reg <= 8'h00;
			eccpg_reg     <= 16'h0000;
			hdr_reg       <= 32'h00000000;
			rxsh_reg      <= 32'h00000000;
			left_reg      <= 6'h00;
			rxn_reg       <= 10'h000;
			rxtot_reg     <= 10'h000;
			dcnt_reg      <= 7'h00;
			dptr_reg      <= 7'h00;
			dbit_reg      <= 3'h0;
			dsh_reg       <= 8'h00;
			quad_reg      <= 1'b0;
			gap_reg       <= 2'h0;
			SPI_SCK       <= 1'b0;
			SPI_CS_N      <= 1'b1;
			IO_OUT        <= IO_IDLE;
			IO_OE         <= OE_SGL;
			for (int i = 0; i < REMAP_LINKS; i++)
				remap_mem[i] <= 32'h00000000;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (cmd_wr) begin
						refused_reg <= !cmd_ok;
						if (cmd_ok) begin
							op_reg    <= WDATA[7:0];
							// latch flag set ahead of every write-type command
							stage_reg <= (is_load(WDATA[7:0]) || is_timed(WDATA[7:0]))
								? SG_WEN : SG_MAIN; // [RULE9] [RULE13] [RULE19]
							st_reg    <= ST_SETUP;
						end
					end
				end

				ST_SETUP: begin
					// timed commands send opcode, dummy byte, then page [RULE8]
					hdr_reg   <= hdr_of(eo, addr_reg) << 1;
					left_reg  <= hbits_of(eo);
					rxtot_reg <= rx_of(eo);
					dcnt_reg  <= is_load(eo) ? len_reg : 7'h00;
					quad_reg  <= is_quad(eo); // [RULE17]
					rxn_reg   <= 10'h000;
					ph_reg    <= PH_HDR;
					SPI_CS_N  <= 1'b0;
					IO_OUT    <= {3'b110, eo[7]};
					IO_OE     <= OE_SGL;
					st_reg    <= ST_XFER;
				end

				ST_XFER: begin
					if (tick && !SPI_SCK) begin
						SPI_SCK <= 1'b1;
						if (ph_reg == PH_RX) begin
							// synchronised pin lags two cycles, well inside a half period
							rxsh_reg <= {rxsh_reg[30:0], io_s_reg[1]};
							rxn_reg  <= rxn_reg + 10'h001;
						end
					end else if (tick) begin
						SPI_SCK <= 1'b0;
						case (ph_reg)
							PH_HDR: begin
								if (left_reg != 6'h01) begin
									left_reg  <= left_reg - 6'h01;
									hdr_reg   <= hdr_reg << 1;
									IO_OUT[0] <= hdr_reg[31];
								end else if (dcnt_reg != 7'h00) begin
									ph_reg   <= PH_DAT;
									dsh_reg  <= buf_mem[0];
									dptr_reg <= 7'h01;
									dbit_reg <= quad_reg ? 3'h1 : 3'h7;
									IO_OUT   <= quad_reg ? buf_mem[0][7:4]
										: {3'b110, buf_mem[0][7]};
									IO_OE    <= quad_reg ? OE_QUAD : OE_SGL; // [RULE17]
								end else if (rxtot_reg != 10'h000) begin
									// reply starts after the falling edge that ends the header
									ph_reg <= PH_RX; // [RULE2] [RULE7]
								end else begin
									// cs rises on the falling edge after the last latched bit
									SPI_CS_N <= 1'b1; // [RULE10]
									IO_OUT   <= IO_IDLE;
									IO_OE    <= OE_SGL;
									gap_reg  <= 2'h0;
									st_reg   <= ST_GAP;
								end
							end
							PH_DAT: begin
								if (dbit_reg != 3'h0) begin
									dbit_reg <= dbit_reg - 3'h1;
									dsh_reg  <= quad_reg ? {dsh_reg[3:0], 4'h0} : dsh_reg << 1;
									IO_OUT   <= quad_reg ? dsh_reg[3:0] : {3'b110, dsh_reg[6]};
								end else if (dptr_reg != dcnt_reg) begin
									dptr_reg <= dptr_reg + 7'h01;
									dsh_reg  <= nb;
									dbit_reg <= quad_reg ? 3'h1 : 3'h7;
									IO_OUT   <= quad_reg ? nb[7:4] : {3'b110, nb[7]};
								end else begin
									// cs held low across the whole data stream
									SPI_CS_N <= 1'b1; // [RULE14]
									IO_OUT   <= IO_IDLE;
									IO_OE    <= OE_SGL;
									gap_reg  <= 2'h0;
									st_reg   <= ST_GAP;
								end
							end
							default: begin
								if (eo == OP_REMAP && rxn_reg[4:0] == 5'h00)
									remap_mem[5'(rxn_reg[9:5] - 5'h01)] <= rxsh_reg; // [RULE1] [RULE3]
								if (rxn_reg == rxtot_reg) begin
									if (eo == OP_STAT)
										stat_byte_reg <= rxsh_reg[7:0];
									if (eo == OP_ECCPG)
										eccpg_reg <= rxsh_reg[15:0]; // [RULE7]
									SPI_CS_N <= 1'b1;
									gap_reg  <= 2'h0;
									st_reg   <= ST_GAP;
								end
							end
						endcase
					end
				end

				ST_GAP: begin
					if (tick) begin
						gap_reg <= gap_reg + 2'h1;
						if (gap_reg == 2'(CS_GAP_TICKS - 1)) begin
							case (stage_reg)
								SG_WEN: begin
									stage_reg <= SG_MAIN;
									st_reg    <= ST_SETUP;
								end
								SG_MAIN: begin
									// nothing but status reads until busy clears
									stage_reg <= SG_POLL; // [RULE11] [RULE25]
									st_reg    <= is_timed(op_reg) ? ST_SETUP : ST_IDLE;
								end
								default: begin
									st_reg <= stat_byte_reg[BUSY_BIT] ? ST_SETUP : ST_IDLE; // [RULE23]
								end
							endcase
						end
					end
				end

				default: st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// [hw/snh_pkg.sv]
package snh_pkg;
	localparam int SYS_CLK_NS    = 10;
	localparam int SCK_HALF_NS   = 50;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int CS_GAP_NS     = 100;
	localparam int CS_GAP_TICKS  = (CS_GAP_NS + SCK_HALF_NS - 1) / SCK_HALF_NS;

	localparam logic [7:0] OP_WEN    = 8'h06;
	localparam logic [7:0] OP_STAT   = 8'h0F;
	localparam logic [7:0] OP_REMAP  = 8'hA5;
	localparam logic [7:0] OP_ECCPG  = 8'hA9;
	localparam logic [7:0] OP_ERASE  = 8'hD8;
	localparam logic [7:0] OP_LOAD   = 8'h02;
	localparam logic [7:0] OP_RLOAD  = 8'h84;
	localparam logic [7:0] OP_QLOAD  = 8'h32;
	localparam logic [7:0] OP_QRLOAD = 8'h34;
	localparam logic [7:0] OP_PEXEC  = 8'h10;
	localparam logic [7:0] STAT_ADDR = 8'hC0;

	localparam int         BUSY_BIT    = 0;
	localparam int         REMAP_LINKS = 20;
	localparam logic [9:0] REMAP_BITS  = 10'd640;
	localparam logic [9:0] ECCPG_BITS  = 10'd16;
	localparam logic [9:0] STAT_BITS   = 10'd8;
	localparam logic [2:0] PARTIAL_MAX = 3'd4;
	localparam int         BUF_BYTES   = 64;

	localparam logic [7:0] REG_CMD   = 8'h00;
	localparam logic [7:0] REG_ADDR  = 8'h04;
	localparam logic [7:0] REG_LEN   = 8'h08;
	localparam logic [7:0] REG_CFG   = 8'h0C;
	localparam logic [7:0] REG_STAT  = 8'h10;
	localparam logic [7:0] REG_ECCPG = 8'h14;
	localparam logic [1:0] REG_BUF_HI   = 2'b01;
	localparam logic [7:0] REG_REMAP = 8'h80;

	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [6:0]  LEN_RST  = 7'h01;
	localparam logic [3:0]  IO_IDLE  = 4'hD;
	localparam logic [3:0]  OE_SGL   = 4'hD;
	localparam logic [3:0]  OE_QUAD  = 4'hF;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_XFER  = 2'b10,
		ST_GAP   = 2'b11
	} snh_state_t;

	typedef enum logic [1:0] {
		SG_WEN  = 2'b00,
		SG_MAIN = 2'b01,
		SG_POLL = 2'b10
	} snh_stage_t;

	typedef enum logic [1:0] {
		PH_HDR = 2'b00,
		PH_DAT = 2'b01,
		PH_RX  = 2'b10
	} snh_phase_t;

	function automatic logic is_quad(input logic [7:0] op);
		return op == OP_QLOAD || op == OP_QRLOAD;
	endfunction

	function automatic logic is_load(input logic [7:0] op);
		return op == OP_LOAD || op == OP_RLOAD || is_quad(op);
	endfunction

	function automatic logic is_timed(input logic [7:0] op);
		return op == OP_ERASE || op == OP_PEXEC;
	endfunction

	function automatic logic valid_op(input logic [7:0] op);
		return is_load(op) || is_timed(op) || op == OP_WEN || op == OP_STAT
			|| op == OP_REMAP || op == OP_ECCPG;
	endfunction

	function automatic logic [5:0] hbits_of(input logic [7:0] op);
		if (is_timed(op))
			return 6'd32;
		else if (is_load(op))
			return 6'd24;
		else if (op == OP_WEN)
			return 6'd8;
		else
			return 6'd16;
	endfunction

	function automatic logic [9:0] rx_of(input logic [7:0] op);
		case (op)
			OP_REMAP: return REMAP_BITS;
			OP_ECCPG: return ECCPG_BITS;
			OP_STAT:  return STAT_BITS;
			default:  return 10'd0;
		endcase
	endfunction

	function automatic logic [31:0] hdr_of(input logic [7:0] op, input logic [15:0] a);
		if (is_timed(op))
			return {op, 8'h00, a};
		else if (is_load(op))
			return {op, a, 8'h00};
		else if (op == OP_STAT)
			return {op, STAT_ADDR, 16'h0000};
		else
			return {op, 24'h000000};
	endfunction
endpackage

// [tb/snh_ctrl_sva.sv]
`timescale 1ns/1ps
module snh_ctrl_chk import snh_pkg::*; (
	input wire logic       SYS_CLK,
	input wire logic       RESETN,
	input wire logic       SPI_SCK,
	input wire logic       SPI_CS_N,
	input wire logic [3:0] IO_OUT,
	input wire logic [3:0] IO_OE
);
	logic       sck_q;
	logic [2:0] bit_cnt;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	// quad clocks carry four bits, so frames end on whole bytes either way
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sck_q   <= 1'b0;
			bit_cnt <= 3'h0;
		end else begin
			sck_q <= SPI_SCK;
			if (SPI_CS_N)
				bit_cnt <= 3'h0;
			else if (SPI_SCK && !sck_q)
				bit_cnt <= bit_cnt + ((IO_OE == OE_QUAD) ? 3'h4 : 3'h1);
		end
	end
	chk_sck_idle: assert property (SPI_CS_N |-> !SPI_SCK)
		else $error("clock moved outside a frame");
	chk_sck_high: assert property ($rose(SPI_SCK) |-> SPI_SCK[*5] ##1 !SPI_SCK)
		else $error("clock high phase wrong");
	chk_first_edge: assert property ($fell(SPI_CS_N) |-> !SPI_SCK[*5] ##1 SPI_SCK)
		else $error("first clock edge misplaced");
	chk_cs_gap: assert property ($rose(SPI_CS_N) |-> SPI_CS_N[*8])
		else $error("select gap too short");
	chk_whole_bytes: assert property ($rose(SPI_CS_N) |-> bit_cnt == 3'h0)
		else $error("frame ended mid byte");
	chk_pins_single: assert property (IO_OE != OE_QUAD |-> IO_OE == OE_SGL && IO_OUT[3:2] == 2'h3)
		else $error("pin drive wrong outside quad data");
	chk_quad_framed: assert property (IO_OE == OE_QUAD |-> !SPI_CS_N)
		else $error("quad drive outside frame");
	chk_data_stable: assert property (SPI_SCK |-> $stable(IO_OUT) && $stable(IO_OE))
		else $error("data moved while clock high");
endmodule

// [tb/snh_dev.sv]
`timescale 1ns/1ps
module snh_dev (
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] io,
	output logic            so
);
	logic [639:0] lut = {32'h80050123, 32'hC0070200, 576'h0};
	logic [639:0] rep;
	logic [31:0]  hdr;
	logic [15:0]  col, last_pg;
	logic [15:0]  bad_pg = 16'h0ABC;
	logic [7:0]   op, byt;
	logic [7:0]   dbuf [0:63];
	logic         write_latch_flag = 1'b0;
	logic         busy = 1'b0;
	logic         wpe = 1'b0;
	logic         prot = 1'b1; // top block protected
	logic         ecc_on = 1'b0; // correction off: tail of buffer kept as loaded
	logic [1:0]   ecc_res = 2'b10; // last continuous read failed
	wire          full = lut[31:0] != 32'h0; // last link used means table full
	int           cnt = 0;
	int           nb = 0;
	int           erase_n = 0;
	int           prog_n = 0;
	wire          quad = op == 8'h32 || op == 8'h34;
	wire          ld = quad || op == 8'h02 || op == 8'h84;
	wire          take = write_latch_flag && !busy && !(quad && wpe);
	initial so = 1'b0;
	always @(posedge sck) if (!cs_n) begin
		hdr = {hdr[30:0], io[0]};
		if (cnt == 7) begin
			op = hdr[7:0];
			rep = op == 8'hA5 ? lut : op == 8'hA9 ? {bad_pg, 624'h0}
				: {5'h0, full, write_latch_flag, busy, 632'h0};
			if (op == 8'hA9 && !ecc_res[1])
				rep = 640'h0;
		end
		if (cnt == 23) begin
			col = hdr[15:0];
			if (take && (op == 8'h02 || op == 8'h32))
				foreach (dbuf[i]) dbuf[i] = 8'hFF;
		end
		byt = (cnt >= 24 && quad) ? {byt[3:0], io} : {byt[6:0], io[0]};
		if (cnt >= 24 && ld && take && (quad ? cnt % 2 == 1 : cnt % 8 == 7)) begin
			if (nb < 64 && !(ecc_on && nb >= 56))
				dbuf[nb] = byt;
			nb++;
		end
		cnt++;
	end
	always @(negedge sck) if (!cs_n && cnt >= 16) begin
		so <= rep[639];
		rep = rep << 1;
	end
	// released line shows the inverse, never a stale bit
	always @(posedge cs_n) begin
		so <= ~so;
		if (!busy && op == 8'h06 && cnt == 8)
			write_latch_flag = 1'b1;
		if (take && (op == 8'hD8 || op == 8'h10) && cnt == 32
			&& !(prot && hdr[15:6] == 10'h3FF)) begin
			busy = 1'b1;
			last_pg = hdr[15:0];
			if (op == 8'hD8)
				erase_n++;
			else
				prog_n++;
		end
		cnt = 0;
		nb = 0;
	end
	always @(posedge busy) begin
		#2000;
		busy = 1'b0;
		write_latch_flag = 1'b0;
	end
endmodule

// [tb/snh_ctrl_bench.sv]
`timescale 1ns/1ps
module snh_ctrl_bench import snh_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata, st;
	logic        sck, cs_n, so;
	logic [3:0]  io_out, io_oe;
	wire  [3:0]  io_in = (io_out & io_oe) | {2'h0, so & ~io_oe[1], 1'b0};
	int          err_total = 0;
	int          checked = 0;
	always #5 clk = ~clk;
	snh_ctrl snh_ctrl_i (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .SPI_SCK(sck), .SPI_CS_N(cs_n), .IO_OUT(io_out),
		.IO_OE(io_oe), .IO_IN(io_in));
	snh_dev snh_dev_i (.sck(sck), .cs_n(cs_n), .io(io_in), .so(so));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded poll: a hung link ends the run instead of stalling it
	task automatic run(input logic [7:0] op);
		int n;
		wreg(REG_CMD, {24'h0, op});
		for (n = 0; n < 5000; n++) begin
			rreg(REG_STAT, st);
			if (st[0] === 1'b0)
				break;
		end
		if (n == 5000) begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic t_erase;
		run(OP_STAT);
		check(st & 32'hFF03, 32'h0);
		wreg(REG_ADDR, 32'h0040);
		run(OP_ERASE);
		check(snh_dev_i.erase_n, 32'h1);
		check(snh_dev_i.last_pg, 32'h0040);
		check(st & 32'hFF03, 32'h0);
		$display("status and erase test done");
	endtask
	task automatic t_load;
		logic [7:0]  ops [4] = '{OP_LOAD, OP_RLOAD, OP_QLOAD, OP_QRLOAD};
		logic [23:0] exp;
		for (int k = 0; k < 4; k++) begin
			wreg(8'h40, {16'h0, 8'hC0 + 8'(k), 8'hA0 + 8'(k)});
			wreg(REG_LEN, k % 2 ? 32'h1 : 32'h2);
			wreg(REG_ADDR, 32'hF123);
			run(ops[k]);
			exp = {8'hA0 + 8'(k), 8'hC0 + 8'(k - k % 2), 8'hFF};
			check(snh_dev_i.col, 32'hF123);
			check({snh_dev_i.dbuf[0], snh_dev_i.dbuf[1], snh_dev_i.dbuf[2]}, exp);
		end
		wreg(REG_CFG, 32'h1);
		run(OP_QLOAD);
		check(st[1], 32'h1);
		wreg(REG_CFG, 32'h0);
		$display("load test done");
	endtask
	task automatic t_prog;
		logic [15:0] pg [7] = '{16'h41, 16'h41, 16'h41, 16'h41, 16'h41, 16'h40, 16'h42};
		for (int k = 0; k < 7; k++) begin
			wreg(REG_ADDR, {16'h0, pg[k]});
			run(OP_PEXEC);
			check(st[1], 32'(k == 4 || k == 5));
			check(snh_dev_i.prog_n, 32'(k < 4 ? k + 1 : (k == 6 ? 5 : 4)));
		end
		$display("program test done");
	endtask
	task automatic t_remap;
		logic [31:0] d;
		run(OP_REMAP);
		for (int i = 0; i < REMAP_LINKS; i++) begin
			rreg(REG_REMAP + 8'(4 * i), d);
			check(d, i == 0 ? 32'h80050123 : i == 1 ? 32'hC0070200 : 32'h0);
		end
		run(OP_ECCPG);
		rreg(REG_ECCPG, d);
		check(d, 32'h0ABC);
		rreg(8'hFC, d);
		check(d, 32'h0);
		rreg(REG_ADDR, d);
		check(d, 32'h0042);
		rreg(REG_CFG, d);
		check(d, 32'h0);
		wreg(REG_LEN, 32'h50);
		rreg(REG_LEN, d);
		check(d, 32'h40);
		run(8'h55);
		check(st[1], 32'h1);
		$display("remap and failing page test done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_erase();
		t_load();
		t_prog();
		t_remap();
		complete_run();
	end
endmodule
bind snh_ctrl snh_ctrl_chk snh_ctrl_chk_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .SPI_SCK(SPI_SCK),
	.SPI_CS_N(SPI_CS_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE));
